// ===== logic/ahi_host_if.sv
// Purpose: host-facing digital interface of a six-channel sampling converter
// Assumes: analog cores present sampleValue, stable at the end of conversion
// Notes:   parallel_bus is split into in, out and active-low output enable
//          strobes are synchronised, so each answer lags its pin by three edges
//          the host keeps chip select high one serial clock period between frames
`default_nettype none

module ahi_host_if
	import ahi_pkg::*;
(
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         serialClk,
	input  wire logic                         chipSelect_n,
	input  wire logic                         readStrobe_n,
	input  wire logic                         writeStrobe_n,
	input  wire logic                         softwareMode,
	input  wire logic                         interfacePick,
	input  wire logic [ahi_pkg::PAIR_N-1:0]   sampleTrigger,
	input  wire logic [ahi_pkg::DATA_W-1:0]   sampleValue [ahi_pkg::CHAN_N],
	input  wire logic [ahi_pkg::DATA_W-1:0]   parallelBusIn,
	output var  logic [ahi_pkg::DATA_W-1:0]   parallelBusOut,
	output var  logic [ahi_pkg::DATA_W-1:0]   parallelBusOe_n,
	output var  logic                         busy,
	output var  logic [ahi_pkg::PAIR_N-1:0]   holdPair,
	output var  logic                         internalVrefOn,
	output var  logic [ahi_pkg::CTRL_W-1:0]   ctrlReg,
	output var  logic                         chainModeOn
);

	import ahi_pkg::*;

	// synchronised pins; strobes cross inverted so that a cleared
	// stage reads as a released pin
	logic                  csLow;
	logic                  rdLow;
	logic                  wrLow;
	logic                  csSync_n;
	logic                  rdSync_n;
	logic                  wrSync_n;
	logic                  swSync;
	logic                  serialSync;
	logic [PAIR_N-1:0]     trigSync;
	logic [DATA_W-1:0]     busSync;
	logic [CNT_W-1:0]      graySync;
	logic [CNT_W-1:0]      grayLink;

	// edge history
	logic [PAIR_N-1:0]     trigPrev_reg;
	logic                  rdPrev_reg;
	logic [PAIR_N-1:0]     trigRise;
	logic                  readDone;

	// conversion sequencer
	ahi_conv_state_t       convState_reg;
	logic [CONV_CNT_W-1:0] convCnt_reg;
	logic [PAIR_N-1:0]     started_reg;

	// results and readout
	logic [DATA_W-1:0]     result_reg [CHAN_N];
	logic [2:0]            chanPtr_reg;
	logic [CNT_W-1:0]      bitIdx;
	logic [1:0]            laneCount;
	logic                  parallelRead;
	logic                  parallelWrite;

	// gray to binary conversion of the serial bit count
	function automatic logic [CNT_W-1:0] grayToBin(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b = '0;
		b[CNT_W-1] = g[CNT_W-1];
		for (int i = CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// bit that a lane carries at a given frame position
	// positions past the lane's share of words read as zero
	function automatic logic laneBit(
		input logic [1:0]       lane,
		input logic [1:0]       lanes,
		input logic [CNT_W-1:0] idx,
		input logic [DATA_W-1:0] words [CHAN_N]
	);
		logic [2:0] perLane;
		logic [2:0] wordNum;
		logic [3:0] bitNum;
		logic [2:0] chan;
		perLane = 3'd6;
		case (lanes)
			2'd2:    perLane = 3'd3;
			2'd3:    perLane = 3'd2;
			default: perLane = 3'd6;
		endcase
		wordNum = idx[CNT_W-1:4] > 3'd7 ? 3'd7 : 3'(idx[CNT_W-1:4]);
		bitNum  = 4'd15 - idx[3:0];
		chan    = 3'(lane * perLane + wordNum);
		if (wordNum >= perLane || chan >= 3'(CHAN_N))
			return 1'b0;
		return words[chan][bitNum];
	endfunction

	// whether a lane carries data for the selected lane count
	function automatic logic laneOn(input logic [1:0] lane, input logic [1:0] lanes);
		return lanes > lane;
	endfunction

	// pins from the host pass two flip-flops before use, apart from serial clock and chip select at the link counter
	// strobes go in inverted: a stage cleared by reset then reads as a
	// released pin, so no read, write or reference change follows reset
	ahi_sync #(.W(5)) ctrlSync (
		.clk     (sys_clk),
		.rst     (rst),
		.asyncIn ({~chipSelect_n, ~readStrobe_n, ~writeStrobe_n, softwareMode,
		           interfacePick}),
		.syncOut ({csLow, rdLow, wrLow, swSync, serialSync})
	);

	// active-low views of the synchronised strobes
	assign csSync_n = !csLow;
	assign rdSync_n = !rdLow;
	assign wrSync_n = !wrLow;

	ahi_sync #(.W(PAIR_N)) trigSyncInst (
		.clk     (sys_clk),
		.rst     (rst),
		.asyncIn (sampleTrigger),
		.syncOut (trigSync)
	);

	ahi_sync #(.W(DATA_W)) busSyncInst (
		.clk     (sys_clk),
		.rst     (rst),
		.asyncIn (parallelBusIn),
		.syncOut (busSync)
	);

	// serial clock
	// link side counts host clock edges within the frame
	ahi_link_count linkCount (
		.serialClk    (serialClk),
		.chipSelect_n (chipSelect_n),
		.grayCount    (grayLink)
	);

	// gray count crosses into sys_clk domain; a chip select rise clears it
	// in one step, which may move several bits, so it settles while cs is high
	ahi_sync #(.W(CNT_W)) graySyncInst (
		.clk     (sys_clk),
		.rst     (rst),
		.asyncIn (grayLink),
		.syncOut (graySync)
	);

	// edge history for triggers and read strobe
	// both start at their pins' idle levels, so reset gives no false edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trigPrev_reg <= '0;
			rdPrev_reg   <= 1'b1;
		end else begin
			trigPrev_reg <= trigSync;
			rdPrev_reg   <= rdSync_n;
		end
	end

	// triggers rising in one sampled cycle start together
	// rising trigger edge
	assign trigRise = trigSync & ~trigPrev_reg;

	// serial mode refuses parallel reads and writes
	// interface pick
	// decode of parallel strobes, only while parallel is picked
	assign parallelRead  = !serialSync && !csSync_n && !rdSync_n;
	assign parallelWrite = !serialSync && swSync && !csSync_n && !wrSync_n;
	assign readDone      = !serialSync && !csSync_n && rdSync_n && !rdPrev_reg;

	// serial frame position and number of active lanes
	// a C select gives three lanes even with B low
	assign bitIdx = grayToBin(graySync);
	assign laneCount = busSync[SEL_C_BIT] ? 2'd3 : (busSync[SEL_B_BIT] ? 2'd2 : 2'd1);

	// edges ignored while busy
	// sequencer: start, wait conversion time, latch, release busy
	// run counts CONV_CYCLES - 1 cycles, the latch cycle is the last one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			convState_reg <= CONV_IDLE;
			convCnt_reg   <= '0;
			started_reg   <= '0;
			busy          <= 1'b0;
			holdPair      <= '0;
		end else begin
			case (convState_reg)
				CONV_IDLE: begin
					if (trigRise != '0) begin
						convState_reg <= CONV_RUN;
						convCnt_reg   <= '0;
						started_reg   <= trigRise;
						busy          <= 1'b1;
						holdPair      <= trigRise;
					end
				end
				CONV_RUN: begin
					convCnt_reg <= convCnt_reg + CONV_CNT_W'(1);
					if (convCnt_reg == CONV_CNT_W'(CONV_CYCLES - 2))
						convState_reg <= CONV_LATCH;
				end
				CONV_LATCH: begin
					convState_reg <= CONV_IDLE;
					busy          <= 1'b0;
					holdPair      <= '0;
					started_reg   <= '0;
				end
				default: begin
					convState_reg <= CONV_IDLE;
					busy          <= 1'b0;
					holdPair      <= '0;
				end
			endcase
		end
	end

	// latch on the same edge that busy falls
	// results of started pairs stored in the latch state
	// pairs not started keep their last results
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int c = 0; c < CHAN_N; c++) begin
				result_reg[c] <= DATA_RESET;
			end
		end else if (convState_reg == CONV_LATCH) begin
			for (int c = 0; c < CHAN_N; c++) begin
				if (started_reg[c/2])
					result_reg[c] <= sampleValue[c];
			end
		end
	end

	// readout pointer: rewinds on new results, steps on each read
	// a latch wins over a read ending in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chanPtr_reg <= '0;
		end else if (convState_reg == CONV_LATCH) begin
			chanPtr_reg <= '0;
		end else if (readDone) begin
			chanPtr_reg <= (chanPtr_reg == 3'(CHAN_N - 1)) ? 3'd0 : chanPtr_reg + 3'd1;
		end
	end

	// loaded every cycle the strobes stay low in software mode, the last byte stays
	// control byte write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrlReg <= CTRL_RESET;
		end else if (parallelWrite) begin
			ctrlReg <= busSync[DATA_W-1:CTRL_LSB];
		end
	end

	// reference from write pin
	// in software mode the last hardware setting is kept
	// the pin is a level here, so no strobe edge is needed
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			internalVrefOn <= VREF_RESET;
		end else if (!swSync) begin
			internalVrefOn <= wrSync_n;
		end
	end

	// chain mode is only reported, daisy-chain shifting is not handled here
	// chain enable input
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chainModeOn <= 1'b0;
		end else begin
			chainModeOn <= serialSync && busSync[CHAIN_BIT];
		end
	end

	// bus drive: parallel word or serial lanes
	// in serial mode lines off the lanes stay released, and so do lanes B and C
	// beyond the lane count; lane A is always driven, so the board may leave the others open
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			parallelBusOut  <= '0;
			parallelBusOe_n <= '1;
		end else if (!serialSync) begin
			parallelBusOut  <= result_reg[chanPtr_reg];
			parallelBusOe_n <= parallelRead ? '0 : '1;
		end else begin
			parallelBusOut  <= '0;
			parallelBusOe_n <= '1;
			parallelBusOut[LANE_A_BIT]  <= laneBit(2'd0, laneCount, bitIdx, result_reg);
			parallelBusOe_n[LANE_A_BIT] <= 1'b0;
			if (laneOn(2'd1, laneCount)) begin
				parallelBusOut[LANE_B_BIT]  <= laneBit(2'd1, laneCount, bitIdx, result_reg);
				parallelBusOe_n[LANE_B_BIT] <= 1'b0;
			end
			if (laneOn(2'd2, laneCount)) begin
				parallelBusOut[LANE_C_BIT]  <= laneBit(2'd2, laneCount, bitIdx, result_reg);
				parallelBusOe_n[LANE_C_BIT] <= 1'b0;
			end
		end
	end

endmodule // ahi_host_if

`default_nettype wire

// ===== logic/ahi_pkg.sv
// Purpose: shared constants and types for the converter host interface
// Assumes: sys_clk at 125 MHz, 16-bit results, six channels in three pairs
// Notes:   bus line positions name the shared parallel/serial pin roles
`default_nettype none

package ahi_pkg;

	// data path sizes
	localparam int DATA_W = 16;
	localparam int CHAN_N = 6;
	localparam int PAIR_N = 3;
	localparam int CTRL_W = 8;
	localparam int LANE_N = 3;
	localparam int CNT_W  = 7;

	// parallel_bus line roles
	localparam int CTRL_LSB   = 8;  // control byte sits on lines 15..8
	localparam int LANE_A_BIT = 8;  // serial output A
	localparam int LANE_B_BIT = 9;  // serial output B
	localparam int LANE_C_BIT = 10; // serial output C
	localparam int CHAIN_BIT  = 7;  // chain_mode_on input
	localparam int SCLK_BIT   = 6;  // host serial clock input
	localparam int SEL_A_BIT  = 0;  // lane A select input
	localparam int SEL_B_BIT  = 1;  // lane B select input
	localparam int SEL_C_BIT  = 2;  // lane C select input

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET  = 8'h00;
	localparam logic              VREF_RESET  = 1'b1;
	localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;

	// serial frame length: all six words on one lane
	localparam int SERIAL_BITS = CHAN_N * DATA_W;

	// conversion time, least time rounded up to whole cycles
	localparam int SYS_CLK_PERIOD_NS = 8;
	localparam int CONV_TIME_NS      = 3000;
	localparam int CONV_CYCLES       =
		(CONV_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int CONV_CNT_W        = 12;

	// conversion sequencer states
	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_RUN,
		CONV_LATCH
	} ahi_conv_state_t;

endpackage

`default_nettype wire

// ===== logic/ahi_sync.sv
// Purpose: two flip-flop synchroniser for levels from another domain
// Assumes: each bit is an independent level
// Notes:   the first stage feeds only the second stage
`default_nettype none

module ahi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] asyncIn,
	output var  logic [W-1:0] syncOut
);

	logic [W-1:0] meta_reg;

	// two stages, cleared by the synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			syncOut  <= '0;
		end else begin
			meta_reg <= asyncIn;
			syncOut  <= meta_reg;
		end
	end

endmodule // ahi_sync

`default_nettype wire

// ===== logic/ahi_link_count.sv
// Purpose: counts host serial clock falling edges inside a frame
// Assumes: serial clock stands still outside frames
// Notes:   frame end is taken from chip select itself, count leaves gray coded
`default_nettype none

module ahi_link_count
	import ahi_pkg::*;
(
	input  wire logic             serialClk,
	input  wire logic             chipSelect_n,
	output var  logic [CNT_W-1:0] grayCount
);

	logic [CNT_W-1:0] binCount_reg;
	logic [CNT_W-1:0] binCount_next;

	// saturate at the end of the longest frame
	always_comb begin
		binCount_next = binCount_reg;
		if (binCount_reg != CNT_W'(SERIAL_BITS))
			binCount_next = binCount_reg + CNT_W'(1);
	end

	// chip select high clears the count with no clock edge needed
	always_ff @(negedge serialClk or posedge chipSelect_n) begin
		if (chipSelect_n) begin
			binCount_reg <= '0;
			grayCount    <= '0;
		end else begin
			binCount_reg <= binCount_next;
			grayCount    <= binCount_next ^ (binCount_next >> 1);
		end
	end

endmodule // ahi_link_count

`default_nettype wire

// ===== dv/ahi_host_if_sva.sv
// Purpose: port checks for the converter host interface
// Assumes: pins pass two sync stages, answers land within 3 edges
// Notes:   bound to every instance of the interface block
`default_nettype none

module ahi_host_if_sva
	import ahi_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        chipSelect_n,
	input wire logic        readStrobe_n,
	input wire logic        writeStrobe_n,
	input wire logic        softwareMode,
	input wire logic        interfacePick,
	input wire logic [2:0]  sampleTrigger,
	input wire logic [15:0] parallelBusIn,
	input wire logic [15:0] parallelBusOe_n,
	input wire logic        busy,
	input wire logic [2:0]  holdPair,
	input wire logic        internalVrefOn,
	input wire logic [7:0]  ctrlReg,
	input wire logic        chainModeOn
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [11:0] busyCnt_reg;

	// cycles spent busy
	always_ff @(posedge sys_clk) begin
		if (rst || !busy)
			busyCnt_reg <= 12'h000;
		else
			busyCnt_reg <= busyCnt_reg + 12'h001;
	end

	AST_BUSY_LEN: assert property ($fell(busy) |-> busyCnt_reg == CONV_CYCLES)
		else $error("busy length wrong");
	AST_HOLD: assert property ($rose(busy) |-> holdPair != 3'h0 ##1 busy[*8])
		else $error("no pair held at start");
	AST_NO_RETRIG: assert property (busy && $past(busy) |-> $stable(holdPair))
		else $error("held pairs changed while busy");
	AST_START: assert property (!busy && $rose(sampleTrigger[0]) |-> ##[2:4] busy)
		else $error("trigger did not start");
	AST_PAR_DRIVE: assert property ((!interfacePick && !chipSelect_n && !readStrobe_n)[*4]
		|-> parallelBusOe_n == 16'h0000) else $error("bus not driven on read");
	AST_PAR_FLOAT: assert property ((!interfacePick && (chipSelect_n || readStrobe_n))[*4]
		|-> parallelBusOe_n == 16'hffff) else $error("bus driven outside read");
	AST_CTRL_WR: assert property ((!interfacePick && softwareMode && !chipSelect_n
		&& !writeStrobe_n && $stable(parallelBusIn))[*4] |-> ctrlReg == parallelBusIn[15:8])
		else $error("control byte not loaded");
	AST_VREF: assert property ((!softwareMode && $stable(writeStrobe_n))[*4]
		|-> internalVrefOn == writeStrobe_n) else $error("reference not following pin");
	AST_SER_IN: assert property (interfacePick[*4]
		|-> parallelBusOe_n[7:0] == 8'hff && parallelBusOe_n[15:11] == 5'h1f)
		else $error("serial input line driven");
	AST_LANE_A: assert property ((interfacePick && !chipSelect_n && parallelBusIn[0])[*4]
		|-> !parallelBusOe_n[8]) else $error("lane A not driven");
	AST_LANE_B: assert property ((interfacePick && parallelBusIn[2:1] == 2'h0)[*4]
		|-> parallelBusOe_n[9]) else $error("lane B driven");
	AST_LANE_C: assert property ((interfacePick && !parallelBusIn[2])[*4]
		|-> parallelBusOe_n[10]) else $error("lane C driven");
	AST_CHAIN: assert property ($stable({interfacePick, parallelBusIn[7]})[*4]
		|-> chainModeOn == (interfacePick && parallelBusIn[7])) else $error("chain mode wrong");
	AST_RST_FLOAT: assert property ($fell(rst) |-> (parallelBusOe_n == 16'hffff
		&& internalVrefOn && !busy)[*3]) else $error("bus or reference disturbed after reset");

	COV_CONV: cover property ($fell(busy));
	COV_SER3: cover property (interfacePick && !parallelBusOe_n[10]);
	COV_WR: cover property (softwareMode && !chipSelect_n && !writeStrobe_n);
endmodule // ahi_host_if_sva

bind ahi_host_if ahi_host_if_sva i_sva (.sys_clk(sys_clk), .rst(rst),
	.chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
	.softwareMode(softwareMode), .interfacePick(interfacePick), .sampleTrigger(sampleTrigger),
	.parallelBusIn(parallelBusIn), .parallelBusOe_n(parallelBusOe_n), .busy(busy),
	.holdPair(holdPair), .internalVrefOn(internalVrefOn), .ctrlReg(ctrlReg),
	.chainModeOn(chainModeOn));

`default_nettype wire

// ===== dv/ahi_host_model.sv
// Purpose: host side of the serial link: frames, clocks, samples lanes
// Assumes: clock idles low, bits are taken on its rising edge
// Notes:   one frame per rising edge of frameGo
`default_nettype none

module ahi_host_model (
	input  wire logic        frameGo,
	input  wire logic [6:0]  frameBits,
	input  wire logic [2:0]  laneLevel,
	output var  logic        chipSelect_n,
	output var  logic        serialClk,
	output var  logic        wordTick,
	output var  logic [15:0] rxWord [3]
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] shiftIn [3];
	int          n;

	initial begin
		chipSelect_n = 1'b1;
		serialClk = 1'b0;
		wordTick = 1'b0;
		forever begin
			@(posedge frameGo);
			chipSelect_n = 1'b0;
			#67; // off the system clock grid
			for (n = 1; n <= frameBits; n++) begin
				serialClk = 1'b1;
				for (int l = 0; l < 3; l++)
					shiftIn[l] = {shiftIn[l][14:0], laneLevel[l]};
				if (n % 16 == 0) begin
					rxWord = shiftIn;
					wordTick = ~wordTick;
				end
				#32 serialClk = 1'b0;
				#32;
			end
			chipSelect_n = 1'b1;
		end
	end
endmodule // ahi_host_model

`default_nettype wire

// ===== dv/ahi_host_if_bench.sv
// Purpose: self-checking bench for the converter host interface
// Assumes: host model runs the serial link at a 64 ns period
// Notes:   expected words queue up, a monitor pops them as they appear
`default_nettype none

module ahi_host_if_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ahi_pkg::*;
	logic        sys_clk, rst, csBench_n, rdStrobe_n, wrStrobe_n, swMode, pick, frameGo;
	logic        busy, vrefOn, chainOn, modelCs_n, sclk, wordTick, chipSel_n, oePrev;
	logic [2:0]  trig, holdPair, laneLevel;
	logic [6:0]  frameBits;
	logic [7:0]  ctrlReg;
	logic [15:0] busHost, busWire, busOut, busOe_n;
	logic [15:0] vals [6];
	logic [15:0] expVal [6];
	logic [15:0] rxWord [3];
	logic [15:0] expQ [$];
	logic [31:0] lfsr;
	int          n_fail, cmp_count, nLanes;

	// wire levels; open lanes read inverted so a float never matches
	assign busWire = (busOut & ~busOe_n) | (busHost & busOe_n);
	assign laneLevel = busOut[10:8] ^ busOe_n[10:8];
	assign chipSel_n = pick ? modelCs_n : csBench_n;

	ahi_host_if i_dut (.sys_clk(sys_clk), .rst(rst), .serialClk(sclk),
		.chipSelect_n(chipSel_n), .readStrobe_n(rdStrobe_n), .writeStrobe_n(wrStrobe_n),
		.softwareMode(swMode), .interfacePick(pick), .sampleTrigger(trig),
		.sampleValue(vals), .parallelBusIn(busWire), .parallelBusOut(busOut),
		.parallelBusOe_n(busOe_n), .busy(busy), .holdPair(holdPair),
		.internalVrefOn(vrefOn), .ctrlReg(ctrlReg), .chainModeOn(chainOn));
	ahi_host_model i_host (.frameGo(frameGo), .frameBits(frameBits), .laneLevel(laneLevel),
		.chipSelect_n(modelCs_n), .serialClk(sclk), .wordTick(wordTick), .rxWord(rxWord));

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// starts the given pairs, then pulses every trigger while busy
	// inputs change mid-conversion: the value standing at the end is expected
	task automatic convert(input logic [2:0] pairs);
		for (int c = 0; c < 6; c++) begin
			lfsr = nextRand(lfsr);
			vals[c] = lfsr[15:0];
			if (pairs[c / 2])
				expVal[c] = ~lfsr[15:0];
		end
		trig = pairs;
		tick(6);
		chk("holdPair", {13'h0, pairs}, {13'h0, holdPair});
		trig = 3'h0;
		tick(2);
		trig = 3'h7;
		tick(2);
		trig = 3'h0;
		for (int c = 0; c < 6; c++)
			vals[c] = ~vals[c];
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			tick(1);
		chk("busy", 16'h0000, {15'h0, busy});
	endtask
	task automatic parRead(input int n);
		for (int w = 0; w < n; w++) begin
			expQ.push_back(expVal[w % 6]);
			csBench_n = 1'b0;
			rdStrobe_n = 1'b0;
			tick(6);
			rdStrobe_n = 1'b1;
			tick(2);
			csBench_n = 1'b1;
			tick(4);
		end
	endtask
	task automatic ctrlWrite(input logic sw, input logic [7:0] d);
		swMode = sw;
		busHost[15:8] = d;
		tick(4);
		csBench_n = 1'b0;
		wrStrobe_n = 1'b0;
		tick(6);
		if (!sw)
			chk("vref", 16'h0000, {15'h0, vrefOn});
		wrStrobe_n = 1'b1;
		csBench_n = 1'b1;
		tick(6);
	endtask
	// read strobe low, other lines grounded, selects set up to the lane count, chain bit for three
	task automatic serRead(input int lanes);
		pick = 1'b1;
		rdStrobe_n = 1'b0;
		busHost = {8'h0, 1'(lanes == 3), 4'h0, 3'h7 >> (3 - lanes)};
		nLanes = lanes;
		for (int t = 0; t < 6 / lanes; t++)
			for (int l = 0; l < lanes; l++)
				expQ.push_back(expVal[l * (6 / lanes) + t]);
		frameBits = 7'(96 / lanes);
		tick(10);
		chk("chain", {15'h0, 1'(lanes == 3)}, {15'h0, chainOn});
		frameGo = 1'b1;
		tick(2);
		frameGo = 1'b0;
		for (int i = 0; i < 1000 && modelCs_n !== 1'b1; i++)
			tick(1);
		tick(16);
	endtask

	// compares the oldest note with each word that appears
	always @(negedge sys_clk) begin
		if (oePrev === 1'b1 && busOe_n[0] === 1'b0)
			chk("parallel word", expQ.pop_front(), busWire);
		oePrev = busOe_n[0];
	end
	always @(wordTick) begin
		for (int l = 0; l < nLanes; l++)
			chk("serial word", expQ.pop_front(), rxWord[l]);
	end

	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// watchdog
	initial begin
		#100000;
		n_fail++;
		finish_test();
	end
	// main sequence
	initial begin
		{rst, csBench_n, rdStrobe_n, wrStrobe_n} = 4'hf;
		{swMode, pick, frameGo, trig, frameBits} = '0;
		busHost = 16'h0000;
		lfsr = 32'h0130;
		for (int c = 0; c < 6; c++)
			vals[c] = 16'h0000;
		tick(20);
		chk("reset", 16'h803f, {vrefOn, ctrlReg, busy, 6'h3f});
		chk("reset oe", 16'hffff, busOe_n);
		rst = 1'b0;
		tick(2);
		convert(3'h7);
		parRead(7);
		convert(3'h1);
		parRead(6);
		lfsr = nextRand(lfsr);
		ctrlWrite(1'b1, lfsr[7:0]);
		chk("ctrlReg", {8'h0, lfsr[7:0]}, {8'h0, ctrlReg});
		ctrlWrite(1'b0, ~lfsr[7:0]);
		chk("ctrlReg kept", {8'h0, lfsr[7:0]}, {8'h0, ctrlReg});
		for (int l = 1; l <= 3; l++)
			serRead(l);
		chk("words left", 16'h0000, 16'(expQ.size()));
		finish_test();
	end
endmodule // ahi_host_if_bench

`default_nettype wire
